// [verilog/wse_wake_state_enable.sv]
`timescale 1ns/1ps

// What this block does
// (RULE1) class A button pulse in suspend-to-RAM, bit 3
// (RULE2) class A button pulse in soft-off, bit 2
// (RULE3) button pulse only when output mode zero
// (RULE4) general event enable ignored by outputs
// (RULE5) bit 1 powers on from suspend-to-RAM
// (RULE6) bit 0 powers on from soft-off
// (RULE7) power-on only when external state select zero
// (RULE8) all enables reset to zero
// (RULE9) event select picks which enables are accessed
// (RULE10) class B events hold only bits 1..0
// (RULE11) reserved bits read zero, writes ignored
module wse_wake_state_enable #(
	parameter int EVENTS = 32,
	parameter int PULSE_CYCLES = wse_pkg::BTN_PULSE_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register access
	input wire wse_pkg::wse_bus_type regBus,
	output logic [7:0] rdData,
	// configuration bits held elsewhere
	input wire logic button_output_mode,
	input wire logic external_state_select,
	input wire logic [EVENTS-1:0] general_event_enable,
	// sleep state and events
	input wire wse_pkg::wse_sleep_type sleepState,
	input wire logic [EVENTS-1:0] eventActive,
	// outputs
	output logic power_button_out,
	output logic main_power_on_control
);

	typedef struct packed {
		logic [4:0] wake_event_select;
		logic [EVENTS-1:0][3:0] wake_state_enable;
		logic [EVENTS-1:0] eventPrev;
		logic buttonTrig;
		logic powerOn;
		logic [7:0] rdData;
	} wse_state_type;

	wse_state_type state_ff;
	wse_state_type nxt_state;
	logic [1:0] rstSync_ff;
	logic rstSync_n;
	logic [EVENTS-1:0] rising;
	logic [EVENTS-1:0] btnHit;
	logic [EVENTS-1:0] pwrHit;
	logic [7:0] selMask;
	logic [7:0] selValue;

	// reset release through two flops
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rstSync_ff <= 2'b00;
		else
			rstSync_ff <= {rstSync_ff[0], 1'b1};
	end
	assign rstSync_n = rstSync_ff[1];

	// per-event decode; general_event_enable is deliberately unused
	genvar g;
	generate
		for (g = 0; g < EVENTS; g++)
		begin : gen_evt
			logic isB;
			logic [3:0] en;
			assign isB = wse_pkg::CLASS_B_EVENTS[g];
			assign en = state_ff.wake_state_enable[g];
			assign rising[g] = eventActive[g] && !state_ff.eventPrev[g];
			assign btnHit[g] = rising[g] && !isB && // see RULE10
				((en[wse_pkg::BTN_SUSPEND_BIT] && sleepState.suspendRam) ||
				(en[wse_pkg::BTN_SOFTOFF_BIT] && sleepState.softOff)); // see RULE1, RULE2, RULE4
			assign pwrHit[g] = rising[g] &&
				((en[wse_pkg::PWR_SUSPEND_BIT] && sleepState.suspendRam) ||
				(en[wse_pkg::PWR_SOFTOFF_BIT] && sleepState.softOff)); // see RULE5, RULE6, RULE4
		end
	endgenerate

	assign selMask = wse_pkg::CLASS_B_EVENTS[state_ff.wake_event_select] ?
		wse_pkg::CLASS_B_MASK : wse_pkg::CLASS_A_MASK; // see RULE10
	assign selValue = {4'h0,
		state_ff.wake_state_enable[state_ff.wake_event_select]} & selMask; // see RULE11

	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.eventPrev = eventActive;
		nxt_state.buttonTrig = (|btnHit) && !button_output_mode; // see RULE3
		// power-on stays active until reset, external state select or leaving sleep
		if (external_state_select)
			nxt_state.powerOn = 1'b0; // see RULE7
		else if (|pwrHit)
			nxt_state.powerOn = 1'b1;
		else if (!sleepState.suspendRam && !sleepState.softOff)
			nxt_state.powerOn = 1'b0;
		if (regBus.write && regBus.offset == wse_pkg::EVT_SEL_OFFSET)
			nxt_state.wake_event_select = regBus.wrData[4:0];
		if (regBus.write && regBus.offset == wse_pkg::STATE_EN_OFFSET)
			nxt_state.wake_state_enable[state_ff.wake_event_select] =
				regBus.wrData[3:0] & selMask[3:0]; // see RULE9, RULE11
		if (regBus.read)
		begin
			if (regBus.offset == wse_pkg::EVT_SEL_OFFSET)
				nxt_state.rdData = {3'h0, state_ff.wake_event_select};
			else if (regBus.offset == wse_pkg::STATE_EN_OFFSET)
				nxt_state.rdData = selValue; // see RULE9
			else
				nxt_state.rdData = 8'h00;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
		begin
			state_ff.wake_event_select <= wse_pkg::EVT_SEL_RESET;
			state_ff.wake_state_enable <= '0; // see RULE8
			state_ff.eventPrev <= '0;
			state_ff.buttonTrig <= 1'b0;
			state_ff.powerOn <= 1'b0;
			state_ff.rdData <= 8'h00;
		end
		else
		begin
			state_ff.wake_event_select <= nxt_state.wake_event_select;
			state_ff.wake_state_enable <= nxt_state.wake_state_enable;
			state_ff.eventPrev <= nxt_state.eventPrev;
			state_ff.buttonTrig <= nxt_state.buttonTrig;
			state_ff.powerOn <= nxt_state.powerOn;
			state_ff.rdData <= nxt_state.rdData;
		end
	end

	wse_pulse_gen #(
		.LENGTH(PULSE_CYCLES)
	) u_pulse (
		.ref_clk(ref_clk),
		.rstSync_n(rstSync_n),
		.trigger(state_ff.buttonTrig),
		.pulse(power_button_out)
	);

	assign main_power_on_control = state_ff.powerOn;
	assign rdData = state_ff.rdData;

	property p_btn_mode;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(|btnHit) && button_output_mode |=> !state_ff.buttonTrig;
	endproperty
	a_btn_mode: assert property (p_btn_mode) // see RULE3
		else $error("button pulse despite output mode");

	property p_btn_fire;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(|btnHit) && !button_output_mode && !power_button_out
		|-> ##2 power_button_out;
	endproperty
	a_btn_fire: assert property (p_btn_fire) // see RULE1
		else $error("no button pulse on enabled event");

	property p_btn_softoff;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(|btnHit) && sleepState.softOff && !button_output_mode &&
		!power_button_out |-> ##2 power_button_out;
	endproperty
	a_btn_softoff: assert property (p_btn_softoff) // see RULE2
		else $error("no button pulse in soft-off");

	property p_pwr_fire;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(|pwrHit) && !external_state_select |=> main_power_on_control;
	endproperty
	a_pwr_fire: assert property (p_pwr_fire) // see RULE5
		else $error("power-on not activated");

	// events whose general enable is clear must still power on
	property p_pwr_gee;
		@(posedge ref_clk) disable iff (!rstSync_n)
		(|(pwrHit & ~general_event_enable)) && !external_state_select
		|=> main_power_on_control;
	endproperty
	a_pwr_gee: assert property (p_pwr_gee) // see RULE4
		else $error("power-on gated by general event enable");

	property p_pwr_ext;
		@(posedge ref_clk) disable iff (!rstSync_n)
		external_state_select |=> !main_power_on_control;
	endproperty
	a_pwr_ext: assert property (p_pwr_ext) // see RULE7
		else $error("power-on while external state select");

	property p_rsvd_read;
		@(posedge ref_clk) disable iff (!rstSync_n)
		regBus.read && regBus.offset == wse_pkg::STATE_EN_OFFSET
		|=> rdData[7:4] == 4'h0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) // see RULE11
		else $error("reserved bits read nonzero");

	property p_classb_btn;
		@(posedge ref_clk) disable iff (!rstSync_n)
		regBus.read && regBus.offset == wse_pkg::STATE_EN_OFFSET &&
		wse_pkg::CLASS_B_EVENTS[state_ff.wake_event_select]
		|=> rdData[3:2] == 2'b00;
	endproperty
	a_classb_btn: assert property (p_classb_btn) // see RULE10
		else $error("class B button bits set");

	property p_wr_rd;
		@(posedge ref_clk) disable iff (!rstSync_n)
		regBus.write && regBus.offset == wse_pkg::STATE_EN_OFFSET
		##1 regBus.read && regBus.offset == wse_pkg::STATE_EN_OFFSET &&
		!$changed(state_ff.wake_event_select)
		|=> rdData == ($past(regBus.wrData, 2) & $past(selMask, 2));
	endproperty
	a_wr_rd: assert property (p_wr_rd) // see RULE9
		else $error("enable readback mismatch");

	property p_reset_clear;
		@(posedge ref_clk) $rose(rstSync_n) |-> state_ff.wake_state_enable == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) // see RULE8
		else $error("enables not cleared by reset");

endmodule

// [verilog/wse_pkg.sv]
package wse_pkg;

	// register offsets within the bank
	localparam logic [7:0] EVT_SEL_OFFSET = 8'h00;
	localparam logic [7:0] STATE_EN_OFFSET = 8'h01;

	// field positions of the wake state enable register
	localparam int BTN_SUSPEND_BIT = 3;
	localparam int BTN_SOFTOFF_BIT = 2;
	localparam int PWR_SUSPEND_BIT = 1;
	localparam int PWR_SOFTOFF_BIT = 0;

	// reset values
	localparam logic [7:0] STATE_EN_RESET = 8'h00;
	localparam logic [4:0] EVT_SEL_RESET = 5'h00;

	// bits kept per event class
	localparam logic [7:0] CLASS_A_MASK = 8'h0F;
	localparam logic [7:0] CLASS_B_MASK = 8'h03;

	// events 19h..1Bh are class B, 17h and 1Dh are unused
	localparam logic [31:0] CLASS_B_EVENTS = 32'h0E00_0000;

	// power button pulse length, in ns, and in cycles at 25 MHz
	localparam int CLK_PERIOD_NS = 40;
	localparam int BTN_PULSE_NS = 1000;
	localparam int BTN_PULSE_CYCLES =
		(BTN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] offset;
		logic [7:0] wrData;
	} wse_bus_type;

	typedef struct packed {
		logic suspendRam;
		logic softOff;
	} wse_sleep_type;

endpackage

// [verilog/wse_pulse_gen.sv]
`timescale 1ns/1ps

// fixed-length pulse from a one-cycle trigger; retriggers while busy are
// folded into the running pulse
module wse_pulse_gen #(
	parameter int LENGTH = 25
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstSync_n,
	// trigger and pulse
	input wire logic trigger,
	output logic pulse
);

	typedef struct packed {
		logic [15:0] count;
		logic active;
	} wse_pulse_state_type;

	wse_pulse_state_type state_ff;
	wse_pulse_state_type nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		if (trigger && !state_ff.active)
		begin
			nxt_state.active = 1'b1;
			nxt_state.count = 16'(LENGTH - 1);
		end
		else if (state_ff.active)
		begin
			if (state_ff.count == 16'h0000)
				nxt_state.active = 1'b0;
			else
				nxt_state.count = state_ff.count - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_n)
	begin
		if (!rstSync_n)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign pulse = state_ff.active;

	property p_pulse_len;
		@(posedge ref_clk) disable iff (!rstSync_n)
		$rose(pulse) |-> pulse [*8];
	endproperty
	a_pulse_len: assert property (p_pulse_len) // see RULE1
		else $error("pulse shorter than expected");

endmodule

// [test/wse_power_partner.sv]
`timescale 1ns/1ps

// power supply and button input: counts button pulses, keeps the last
// pulse length, follows the power-on control level
module wse_power_partner (
	// clock
	input wire logic ref_clk,
	// from the block
	input wire logic power_button_out,
	input wire logic main_power_on_control,
	// observations
	output logic [7:0] pulseCount,
	output logic [7:0] pulseLen,
	output logic mainPowered
);
	logic [7:0] runLen = 8'h00;
	logic lastBtn = 1'b0;
	initial pulseCount = 8'h00;
	initial pulseLen = 8'h00;
	assign mainPowered = main_power_on_control;
	always @(posedge ref_clk)
	begin
		lastBtn <= power_button_out;
		if (power_button_out)
			runLen <= runLen + 8'h01;
		else
			runLen <= 8'h00;
		if (power_button_out && !lastBtn)
			pulseCount <= pulseCount + 8'h01;
		if (!power_button_out && lastBtn)
			pulseLen <= runLen;
	end
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
	localparam int PC = 10;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	wse_pkg::wse_bus_type regBus = '0;
	logic [7:0] rdData;
	logic button_output_mode = 1'b0;
	logic external_state_select = 1'b0;
	logic [31:0] general_event_enable = 32'h0000_0000;
	wse_pkg::wse_sleep_type sleepState = '0;
	logic [31:0] eventActive = 32'h0000_0000;
	logic power_button_out;
	logic main_power_on_control;
	logic [7:0] pulseCount;
	logic [7:0] pulseLen;
	logic mainPowered;
	int n_mismatch = 0;
	int n_tests = 0;

	wse_wake_state_enable #(.EVENTS(32), .PULSE_CYCLES(PC))
		wse_wake_state_enable_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.regBus(regBus), .rdData(rdData),
		.button_output_mode(button_output_mode),
		.external_state_select(external_state_select),
		.general_event_enable(general_event_enable),
		.sleepState(sleepState), .eventActive(eventActive),
		.power_button_out(power_button_out),
		.main_power_on_control(main_power_on_control));
	wse_power_partner wse_power_partner_i (.ref_clk(ref_clk),
		.power_button_out(power_button_out),
		.main_power_on_control(main_power_on_control),
		.pulseCount(pulseCount), .pulseLen(pulseLen),
		.mainPowered(mainPowered));

	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] off, input logic [7:0] data);
		@(posedge ref_clk) regBus <= '{1'b1, 1'b0, off, data};
		@(posedge ref_clk) regBus <= '0;
	endtask

	task rd(input logic [7:0] off, input logic [7:0] exp);
		@(posedge ref_clk) regBus <= '{1'b0, 1'b1, off, 8'h00};
		@(posedge ref_clk) regBus <= '0;
		@(negedge ref_clk) chk(rdData, exp);
	endtask

	// one wake event with the given setup; expected pulse and power-on
	task ev(input logic [4:0] sel, input logic [7:0] en,
		input logic [1:0] st, input logic md, input logic ex,
		input logic expP, input logic expO);
		logic [7:0] base;
		wr(8'h00, {3'h0, sel});
		wr(8'h01, en);
		@(posedge ref_clk)
		begin
			sleepState <= st;
			button_output_mode <= md;
			external_state_select <= ex;
		end
		base = pulseCount;
		@(posedge ref_clk) eventActive[sel] <= 1'b1;
		repeat (PC + 6) @(posedge ref_clk);
		@(negedge ref_clk) chk({7'h0, mainPowered}, {7'h0, expO});
		chk(pulseCount - base, {7'h0, expP});
		if (expP)
			chk(pulseLen, 8'(PC));
		@(posedge ref_clk)
		begin
			eventActive <= 32'h0000_0000;
			sleepState <= '0;
			button_output_mode <= 1'b0;
			external_state_select <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end

	initial
	begin
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk) chk({6'h0, power_button_out, main_power_on_control}, 8'h00);
		rd(8'h01, 8'h00);
		wr(8'h00, 8'h05);
		rd(8'h00, 8'h05);
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h0F);
		wr(8'h00, 8'h06);
		rd(8'h01, 8'h00);
		wr(8'h00, 8'h19);
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h03);
		wr(8'h00, 8'h05);
		rd(8'h01, 8'h0F);
		rd(8'h02, 8'h00);
		// write then read back to back
		@(posedge ref_clk) regBus <= '{1'b1, 1'b0, 8'h01, 8'hA6};
		@(posedge ref_clk) regBus <= '{1'b0, 1'b1, 8'h01, 8'h00};
		@(posedge ref_clk) regBus <= '0;
		@(negedge ref_clk) chk(rdData, 8'h06);
		// general event enables must not gate the outputs
		ev(5'h05, 8'h08, 2'b10, 1'b0, 1'b0, 1'b1, 1'b0);
		@(posedge ref_clk) general_event_enable <= 32'hFDFF_FFFF;
		ev(5'h1F, 8'h04, 2'b01, 1'b0, 1'b0, 1'b1, 1'b0);
		ev(5'h05, 8'h08, 2'b10, 1'b1, 1'b0, 1'b0, 1'b0);
		ev(5'h05, 8'h04, 2'b10, 1'b0, 1'b0, 1'b0, 1'b0);
		ev(5'h00, 8'h02, 2'b10, 1'b0, 1'b0, 1'b0, 1'b1);
		ev(5'h00, 8'h01, 2'b01, 1'b0, 1'b0, 1'b0, 1'b1);
		ev(5'h00, 8'h01, 2'b01, 1'b0, 1'b1, 1'b0, 1'b0);
		ev(5'h19, 8'h0F, 2'b10, 1'b0, 1'b0, 1'b0, 1'b1);
		tally_and_finish;
	end
endmodule
